// File: bench/sfp_host.sv
// Host serial controller model driving the select, clock and data pins.
`timescale 1ns/10ps
module sfp_host (
  // Bench clock.
  input  wire logic       pclk,
  // Device data lines.
  input  wire logic [3:0] dev_out,
  input  wire logic [3:0] dev_oe,
  // Pins towards the device.
  output logic            cs_n,
  output logic            sclk,
  output logic [3:0]      io_wire
);
  logic drv_q   = 1'b1;
  logic guard_q = 1'b1;
  logic pause_q = 1'b1;
  logic flip_q  = 1'b0;
  // Deselected at power-up and the clock idles high between frames.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
  end
  // Released line one, and line zero while deselected, toggle each cycle so a stale value is never read as valid.
  always @(posedge pclk) begin
    flip_q <= ~flip_q;
  end
  // Wire levels; guard and pause are driven by the host unless the device enables lines two and three.
  assign io_wire[0] = dev_oe[0] ? dev_out[0] : (cs_n ? flip_q : drv_q);
  assign io_wire[1] = dev_oe[1] ? dev_out[1] : flip_q;
  assign io_wire[2] = dev_oe[2] ? dev_out[2] : guard_q;
  assign io_wire[3] = dev_oe[3] ? dev_out[3] : pause_q;
  // Changes the select; the first fall after reset opens the link.
  task automatic sel(input logic v);
    @(posedge pclk);
    cs_n <= v;
  endtask
  // One bit in clock mode three: fall and present, optional pause, rise, take line one.
  task automatic bit_step(input logic b, input logic pz, output logic o,
                          output logic [3:0] poe);
    @(posedge pclk);
    sclk <= 1'b0;
    drv_q <= b;
    repeat (4) @(posedge pclk);
    poe = dev_oe;
    if (pz) begin
      pause_q <= 1'b0;
      repeat (8) @(posedge pclk);
      poe = dev_oe;
      pause_q <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    sclk <= 1'b1;
    repeat (4) @(posedge pclk);
    o = io_wire[1];
  endtask
endmodule

// File: bench/sfp_pin_if_tb.sv
// Self-checking bench for the serial flash pin interface.
`timescale 1ns/10ps
module sfp_pin_if_tb;
  // ******************************************************************
  // Signals, counters and instances.
  // ******************************************************************
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h00000000;
  logic        op_busy = 1'b0;
  logic [31:0] prdata, r, k;
  logic        pready, pslverr, err, cs_n, sclk, blk, grd, stby, act;
  logic [3:0]  io_out, io_oe, io_w;
  logic [5:0]  reg6;
  logic [7:0]  tx, rx;
  int          failures   = 0;
  int          num_checks = 0;
  int          cyc        = 0;
  sfp_pin_if sfp_pin_if_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .io_in(io_w), .io_out(io_out),
    .io_oe(io_oe), .op_busy(op_busy), .status_write_blocked(blk), .array_guard(grd),
    .protect_region(reg6), .standby(stby), .active(act));
  sfp_host sfp_host_i (.pclk(pclk), .dev_out(io_out), .dev_oe(io_oe), .cs_n(cs_n),
    .sclk(sclk), .io_wire(io_w));
  // Clock and hang guard.
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      test_done();
    end
  end
  // Counts a comparison and reports a difference.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One APB transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) chk("pready_wait", 32'h1, 32'h0);
  endtask
  // Hardware lock: guard low, upper lock clear, lower lock set, quad enable clear.
  function automatic logic lock_exp(input logic [3:0] i);
    return ~i[0] & i[1] & ~i[2] & ~i[3];
  endfunction
  // Moves one byte each way, optionally pausing inside bit pz before its rising edge, and compares the output.
  task automatic xfer(input logic [7:0] t, input logic [7:0] e, input int pz);
    logic       b;
    logic [7:0] got;
    logic [3:0] poe;
    for (int i = 7; i >= 0; i--) begin
      sfp_host_i.bit_step(t[i], i == pz, b, poe);
      got[i] = b;
      if (i == pz) chk("paused_oe", 32'h0, {28'h0, poe});
    end
    chk("out_byte", {24'h0, e}, {24'h0, got});
  endtask
  // ******************************************************************
  // Main sequence.
  // ******************************************************************
  initial begin
    void'($urandom(32'h97C1FE8C));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(sfp_pkg::ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl_reset", sfp_pkg::CTRL_RESET, r);
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("deselect_oe", 32'h0, {28'h0, io_oe});
    chk("standby", 32'h1, {31'h0, stby});
    op_busy <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("busy_standby", 32'h0, {31'h0, stby});
    op_busy <= 1'b0;
    sfp_host_i.sel(1'b0);
    repeat (6) @(posedge pclk);
    chk("active", 32'h1, {31'h0, act});
    for (int i = 0; i < 16; i++) begin
      k = $urandom;
      sfp_host_i.guard_q <= i[0];
      apb(sfp_pkg::ADDR_CTRL, 1'b1, {20'h0, k[5:0], i[1], i[2], i[3], 3'h0});
      repeat (4) @(posedge pclk);
      chk("blocked", {31'h0, lock_exp(i[3:0])}, {31'h0, blk});
      chk("array_guard", {31'h0, lock_exp(i[3:0])}, {31'h0, grd});
      chk("region", {26'h0, k[5:0]}, {26'h0, reg6});
    end
    sfp_host_i.guard_q <= 1'b1;
    tx = 8'($urandom);
    rx = 8'($urandom);
    apb(sfp_pkg::ADDR_CTRL, 1'b1, 32'h1);
    apb(sfp_pkg::ADDR_TX, 1'b1, {24'h0, tx});
    xfer(rx, tx, 3);
    chk("oe_single", 32'h2, {28'h0, io_oe});
    repeat (4) @(posedge pclk);
    apb(sfp_pkg::ADDR_RX, 1'b0, 32'h0);
    chk("rx_byte", {24'h0, rx}, r);
    apb(sfp_pkg::ADDR_CTRL, 1'b1, 32'h5);
    rx = 8'($urandom);
    xfer(rx, sfp_pkg::IDLE_BYTE, 9);
    repeat (4) @(posedge pclk);
    apb(sfp_pkg::ADDR_STAT, 1'b0, 32'h0);
    chk("quad_refused", 32'h1, {31'h0, r[sfp_pkg::STAT_REFUSED]});
    apb(sfp_pkg::ADDR_RX, 1'b0, 32'h0);
    chk("rx_second", {24'h0, rx}, r);
    sfp_host_i.sel(1'b1);
    repeat (6) @(posedge pclk);
    chk("released_oe", 32'h0, {28'h0, io_oe});
    chk("standby_end", 32'h1, {31'h0, stby});
    test_done();
  end
endmodule

// File: verilog/sfp_fifo.sv
// Small synchronous FIFO that buffers bytes queued for transmission.
`timescale 1ns/10ps
module sfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } sfp_fifo_state_type;

  sfp_fifo_state_type q;
  sfp_fifo_state_type d;
  logic               push;
  logic               pop;

  // Full and empty follow the occupancy count directly.
  assign in_ready  = (q.count != (AW+1)'(DEPTH));
  assign out_valid = (q.count != '0);
  assign out_data  = q.mem[q.rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and storage update; pointers wrap at the depth.
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr_ptr] = in_data;
      d.wr_ptr = (q.wr_ptr == AW'(DEPTH - 1)) ? '0 : q.wr_ptr + AW'(1);
    end
    if (pop) begin
      d.rd_ptr = (q.rd_ptr == AW'(DEPTH - 1)) ? '0 : q.rd_ptr + AW'(1);
    end
    d.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// File: verilog/sfp_pin_if.sv
// Serial flash pin interface front end with an APB register port.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps

// Overview of operation
// - Deselected: ignore all inputs and float every output.
// - Select low means active; deselected and idle core means standby.
// - No instruction accepted until a select falling edge follows power-up.
// - Instruction, address and data bits sampled on serial clock rising edges.
// - Output lines change only after a serial clock falling edge.
// - Dual and quad: lines zero and one receive on rise, drive on fall.
// - Quad mode turns guard and pause pins into data lines two and three.
// - Guard low, upper lock 0, lower lock 1: status writes are rejected.
// - Same lock keeps the protected array region from program and erase.
// - With quad enable set the guard pin has no protection effect.
// - Pause stops serial traffic; internal write operations carry on.
// - Pause needs select low; starts on pause low once clock is low.
// - Pause ends on pause high once the clock is low.
// - While paused the output floats; data in and clock are ignored.
// - Deselecting while paused resets the serial state.
// - Quad width honoured only when the quad enable bit is set.
// - Works with clock idle low or high, modes zero and three.
module sfp_pin_if (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins; each data line has input, output and output enable.
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic [3:0]  io_in,
  output logic [3:0]       io_out,
  output logic [3:0]       io_oe,
  // Flash core side.
  input  wire logic        op_busy,
  output logic             status_write_blocked,
  output logic             array_guard,
  output logic [5:0]       protect_region,
  output logic             standby,
  output logic             active
);

  // ********************************************************************
  // State record.
  // ********************************************************************
  typedef struct packed {
    logic [5:0]           sync1;
    logic [5:0]           sync2;
    logic                 cs_prev;
    logic                 sclk_prev;
    logic                 armed;
    sfp_pkg::sfp_link_type link;
    logic [31:0]          ctrl;
    logic [7:0]           rx_sh;
    logic [3:0]           rx_cnt;
    logic [7:0]           rx_byte;
    logic                 rx_valid;
    logic                 rx_overrun;
    logic [7:0]           tx_sh;
    logic [3:0]           tx_cnt;
    logic [3:0]           io_out;
    logic [3:0]           io_oe;
    logic                 refused;
    logic                 blocked;
    logic                 guard;
    logic                 standby;
    logic [31:0]          prdata;
  } sfp_state_type;

  sfp_state_type q;
  sfp_state_type d;

  logic       cs_s;
  logic       sclk_s;
  logic [3:0] io_s;
  logic [1:0] width_req;
  logic [1:0] width_eff;
  logic       quad_mode;
  logic       qe;
  logic       hold_n;
  logic       wp_n;
  logic       hw_lock;
  logic       rise;
  logic       fall;
  logic       shifting;
  logic       drive_en;
  logic [3:0] nb;
  logic       acc;
  logic       mapped;
  logic       tx_push;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_pop;
  logic [7:0] fifo_data;
  logic [7:0] tx_byte;
  logic [7:0] rx_next;
  logic [3:0] rx_sum;
  logic [31:0] rd_mux;

  // ********************************************************************
  // Width helpers shared by receive, transmit and enable logic.
  // ********************************************************************

  // Bits moved per serial clock for a line width.
  function automatic logic [3:0] bits_per_clk(input logic [1:0] w);
    case (w)
      sfp_pkg::WIDTH_DUAL: bits_per_clk = 4'h2;
      sfp_pkg::WIDTH_QUAD: bits_per_clk = 4'h4;
      default:             bits_per_clk = 4'h1;
    endcase
  endfunction

  // Shifts the sampled lines into the receive byte, most significant first.
  function automatic logic [7:0] gather(input logic [7:0] sh, input logic [3:0] io,
                                       input logic [1:0] w);
    case (w)
      sfp_pkg::WIDTH_DUAL: gather = {sh[5:0], io[1:0]};
      sfp_pkg::WIDTH_QUAD: gather = {sh[3:0], io[3:0]};
      default:             gather = {sh[6:0], io[0]};
    endcase
  endfunction

  // Places the leading bits of a byte onto the data lines.
  function automatic logic [3:0] place(input logic [7:0] b, input logic [1:0] w);
    case (w)
      sfp_pkg::WIDTH_DUAL: place = {2'h0, b[7:6]};
      sfp_pkg::WIDTH_QUAD: place = b[7:4];
      default:             place = {2'h0, b[7], 1'h0};
    endcase
  endfunction

  // Lines that the device drives for a line width.
  function automatic logic [3:0] oe_mask(input logic [1:0] w);
    case (w)
      sfp_pkg::WIDTH_DUAL: oe_mask = 4'h3;
      sfp_pkg::WIDTH_QUAD: oe_mask = 4'hF;
      default:             oe_mask = 4'h2;
    endcase
  endfunction

  // ********************************************************************
  // Synchronised pins and derived control levels.
  // ********************************************************************

  // Only the second synchroniser stage feeds logic.
  assign cs_s      = q.sync2[5];
  assign sclk_s    = q.sync2[4];
  assign io_s      = q.sync2[3:0];
  assign qe        = q.ctrl[sfp_pkg::CTRL_QE];
  assign drive_en  = q.ctrl[sfp_pkg::CTRL_DRIVE];
  assign width_req = q.ctrl[sfp_pkg::CTRL_WIDTH_LO +: 2];
  // A quad request without quad enable falls back to single width.
  assign width_eff = ((width_req == sfp_pkg::WIDTH_QUAD) && !qe) ? sfp_pkg::WIDTH_SINGLE :
                     (width_req == 2'h3) ? sfp_pkg::WIDTH_SINGLE : width_req;
  assign quad_mode = (width_eff == sfp_pkg::WIDTH_QUAD);
  // In quad mode lines two and three carry data, not pause or guard.
  assign hold_n    = quad_mode ? 1'h1 : io_s[3];
  assign wp_n      = (quad_mode || qe) ? 1'h1 : io_s[2];
  // Hardware lock: guard low, upper lock clear, lower lock set.
  assign hw_lock   = !wp_n && !q.ctrl[sfp_pkg::CTRL_LOCK_UP]
                     && q.ctrl[sfp_pkg::CTRL_LOCK_LO];
  // Edges are found on the sampled clock, so either idle level works.
  assign rise      = sclk_s && !q.sclk_prev;
  assign fall      = !sclk_s && q.sclk_prev;
  assign nb        = bits_per_clk(width_eff);

  // ********************************************************************
  // APB decode and read multiplexer.
  // ********************************************************************
  assign acc     = psel && penable;
  assign mapped  = (paddr == sfp_pkg::ADDR_CTRL) || (paddr == sfp_pkg::ADDR_STAT)
                   || (paddr == sfp_pkg::ADDR_RX) || (paddr == sfp_pkg::ADDR_TX);
  assign tx_push = acc && pwrite && (paddr == sfp_pkg::ADDR_TX);
  // A write to a full transmit FIFO waits in the access phase.
  assign pready  = !(tx_push && !fifo_in_ready);
  assign pslverr = acc && !mapped;
  assign prdata  = q.prdata;

  // Read value captured in the setup phase.
  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      sfp_pkg::ADDR_CTRL: rd_mux = q.ctrl;
      sfp_pkg::ADDR_STAT: begin
        rd_mux[sfp_pkg::STAT_ARMED]    = q.armed;
        rd_mux[sfp_pkg::STAT_ACTIVE]   = (q.link != sfp_pkg::LINK_IDLE);
        rd_mux[sfp_pkg::STAT_PAUSED]   = (q.link == sfp_pkg::LINK_PAUSED);
        rd_mux[sfp_pkg::STAT_STANDBY]  = q.standby;
        rd_mux[sfp_pkg::STAT_BLOCKED]  = q.blocked;
        rd_mux[sfp_pkg::STAT_GUARD]    = q.guard;
        rd_mux[sfp_pkg::STAT_RX_VALID] = q.rx_valid;
        rd_mux[sfp_pkg::STAT_OVERRUN]  = q.rx_overrun;
        rd_mux[sfp_pkg::STAT_REFUSED]  = q.refused;
      end
      sfp_pkg::ADDR_RX:   rd_mux = {24'h000000, q.rx_byte};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // ********************************************************************
  // Next-state logic.
  // ********************************************************************
  // Shifting runs while active and neither deselect nor pause entry is pending.
  // It is built from the present state, so the next-state process never feeds itself.
  assign shifting = (q.link == sfp_pkg::LINK_ACTIVE) && !cs_s && (hold_n || sclk_s);
  assign fifo_pop = shifting && fall && drive_en && (q.tx_cnt == 4'h0) && fifo_out_valid;
  assign tx_byte  = (q.tx_cnt != 4'h0) ? q.tx_sh :
                    fifo_out_valid ? fifo_data : sfp_pkg::IDLE_BYTE;
  assign rx_next  = gather(q.rx_sh, io_s, width_eff);
  assign rx_sum   = q.rx_cnt + nb;

  always_comb begin
    d = q;
    // Two-flop synchronisers for select, clock and data lines.
    d.sync1     = {cs_n, sclk, io_in};
    d.sync2     = q.sync1;
    d.cs_prev   = cs_s;
    d.sclk_prev = sclk_s;
    // The first select falling edge arms the interface.
    if (q.cs_prev && !cs_s) begin
      d.armed = 1'h1;
    end
    // Register writes and software clears; hardware sets follow and win.
    if (psel && !penable) begin
      d.prdata = rd_mux;
    end
    if (acc && pwrite && (paddr == sfp_pkg::ADDR_CTRL)) begin
      d.ctrl = pwdata;
    end
    if (acc && pwrite && (paddr == sfp_pkg::ADDR_STAT)) begin
      if (pwdata[sfp_pkg::STAT_OVERRUN]) begin
        d.rx_overrun = 1'h0;
      end
      if (pwdata[sfp_pkg::STAT_REFUSED]) begin
        d.refused = 1'h0;
      end
    end
    if (acc && !pwrite && (paddr == sfp_pkg::ADDR_RX)) begin
      d.rx_valid = 1'h0;
    end
    // Link state: select, pause entry and pause exit on a low clock.
    case (q.link)
      sfp_pkg::LINK_IDLE: begin
        if (!cs_s && q.armed) begin
          d.link = sfp_pkg::LINK_ACTIVE;
        end
      end
      sfp_pkg::LINK_ACTIVE: begin
        if (cs_s) begin
          d.link = sfp_pkg::LINK_IDLE;
        end else if (!hold_n && !sclk_s) begin
          d.link = sfp_pkg::LINK_PAUSED;
        end
      end
      sfp_pkg::LINK_PAUSED: begin
        if (cs_s) begin
          d.link = sfp_pkg::LINK_IDLE;
        end else if (hold_n && !sclk_s) begin
          d.link = sfp_pkg::LINK_ACTIVE;
        end
      end
      default: d.link = sfp_pkg::LINK_IDLE;
    endcase
    // Receive: sample lines on rising clock edges.
    if (shifting && rise) begin
      d.rx_sh = rx_next;
      if (rx_sum >= sfp_pkg::BYTE_BITS) begin
        d.rx_cnt     = 4'h0;
        d.rx_byte    = rx_next;
        d.rx_valid   = 1'h1;
        d.rx_overrun = d.rx_overrun | q.rx_valid;
      end else begin
        d.rx_cnt = rx_sum;
      end
    end
    // Transmit: new line values only after falling clock edges.
    if (shifting && fall && drive_en) begin
      d.io_out = place(tx_byte, width_eff);
      d.tx_sh  = tx_byte << nb;
      d.tx_cnt = ((q.tx_cnt == 4'h0) ? sfp_pkg::BYTE_BITS : q.tx_cnt) - nb;
    end
    if (q.link == sfp_pkg::LINK_ACTIVE && width_req == sfp_pkg::WIDTH_QUAD && !qe) begin
      d.refused = 1'h1;
    end
    // Deselect clears the bit position; a pause leaves it untouched.
    if (d.link == sfp_pkg::LINK_IDLE) begin
      d.rx_cnt = 4'h0;
      d.rx_sh  = 8'h00;
      d.tx_cnt = 4'h0;
      d.tx_sh  = 8'h00;
    end
    // Lines are driven only while actively selected and not paused.
    d.io_oe = (d.link == sfp_pkg::LINK_ACTIVE && drive_en) ?
              oe_mask(width_eff) : 4'h0;
    // Protection and power levels for the flash core.
    d.blocked = hw_lock;
    d.guard   = hw_lock;
    // Internal operations are not stopped by pause; standby needs select high and busy low.
    d.standby = cs_s && !op_busy;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q      <= '0;
      q.ctrl <= sfp_pkg::CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // ********************************************************************
  // Transmit FIFO fed by APB writes, drained by the shifter.
  // ********************************************************************
  sfp_fifo #(
    .WIDTH (sfp_pkg::FIFO_WIDTH),
    .DEPTH (sfp_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (tx_push),
    .in_ready  (fifo_in_ready),
    .in_data   (pwdata[7:0]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Core-facing outputs come straight from state flops.
  assign io_out               = q.io_out;
  assign io_oe                = q.io_oe;
  assign status_write_blocked = q.blocked;
  assign array_guard          = q.guard;
  assign protect_region       = q.ctrl[sfp_pkg::CTRL_PROT_LO +: sfp_pkg::PROT_BITS];
  assign standby              = q.standby;
  assign active               = (q.link != sfp_pkg::LINK_IDLE);

  // ********************************************************************
  // Assertions.
  // ********************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Pause request seen on a low clock while active.
  sequence s_hold_req;
    q.link == sfp_pkg::LINK_ACTIVE && !cs_s && !hold_n && !sclk_s;
  endsequence

  // Pause release seen on a low clock.
  sequence s_hold_rel;
    q.link == sfp_pkg::LINK_PAUSED && !cs_s && hold_n && !sclk_s;
  endsequence

  a_deselect_float: assert property (cs_s |=> io_oe == 4'h0)
    else $error("Lines driven while deselected.");
  a_standby_level: assert property (cs_s && !op_busy |=> standby)
    else $error("Standby missing while idle and deselected.");
  a_unarmed_idle: assert property (!q.armed |-> q.link == sfp_pkg::LINK_IDLE)
    else $error("Link left idle before arming.");
  a_rise_sample: assert property (shifting && rise |=> q.rx_cnt != $past(q.rx_cnt))
    else $error("Rising edge did not advance receive count.");
  a_fall_only: assert property (!(shifting && fall) |=> $stable(io_out))
    else $error("Output changed without a falling edge.");
  a_lock_blocks: assert property (hw_lock |=> status_write_blocked && array_guard)
    else $error("Hardware lock not reported.");
  a_qe_frees_wp: assert property (qe |=> !status_write_blocked)
    else $error("Guard pin honoured with quad enable set.");
  a_hold_entry: assert property (s_hold_req |=> q.link == sfp_pkg::LINK_PAUSED)
    else $error("Pause did not begin.");
  a_hold_exit: assert property (s_hold_rel |=> q.link == sfp_pkg::LINK_ACTIVE)
    else $error("Pause did not end.");
  a_pause_float: assert property (q.link == sfp_pkg::LINK_PAUSED |-> io_oe == 4'h0)
    else $error("Lines driven while paused.");
  a_pause_reset: assert property (q.link == sfp_pkg::LINK_PAUSED && cs_s
                                  |=> q.rx_cnt == 4'h0 && q.tx_cnt == 4'h0)
    else $error("Deselect in pause kept bit position.");
  a_quad_gated: assert property (!qe |=> io_oe != 4'hF)
    else $error("Quad drive without quad enable.");
  a_pause_keeps: assert property (q.link == sfp_pkg::LINK_PAUSED && !cs_s
                                  |=> $stable(q.rx_cnt) && $stable(q.tx_cnt))
    else $error("Bit position moved during pause.");

endmodule

// File: verilog/sfp_pkg.sv
// Shared constants and types for the serial flash pin interface.
package sfp_pkg;

  // ********************************************************************
  // Register byte offsets on the APB slave.
  // ********************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_RX   = 8'h08;
  localparam logic [7:0] ADDR_TX   = 8'h0C;

  // ********************************************************************
  // Control register fields and reset value.
  // ********************************************************************
  localparam int          CTRL_DRIVE    = 0;
  localparam int          CTRL_WIDTH_LO = 1;
  localparam int          CTRL_QE       = 3;
  localparam int          CTRL_LOCK_UP  = 4;
  localparam int          CTRL_LOCK_LO  = 5;
  localparam int          CTRL_PROT_LO  = 6;
  localparam int          PROT_BITS     = 6;
  localparam logic [31:0] CTRL_RESET    = 32'h00000000;

  // ********************************************************************
  // Status register fields.
  // ********************************************************************
  localparam int STAT_ARMED    = 0;
  localparam int STAT_ACTIVE   = 1;
  localparam int STAT_PAUSED   = 2;
  localparam int STAT_STANDBY  = 3;
  localparam int STAT_BLOCKED  = 4;
  localparam int STAT_GUARD    = 5;
  localparam int STAT_RX_VALID = 6;
  localparam int STAT_OVERRUN  = 7;
  localparam int STAT_REFUSED  = 8;

  // ********************************************************************
  // Line width codes, byte framing and the transmit FIFO shape.
  // ********************************************************************
  localparam logic [1:0] WIDTH_SINGLE = 2'h0;
  localparam logic [1:0] WIDTH_DUAL   = 2'h1;
  localparam logic [1:0] WIDTH_QUAD   = 2'h2;
  localparam logic [3:0] BYTE_BITS    = 4'h8;
  localparam logic [7:0] IDLE_BYTE    = 8'hFF;
  localparam int         FIFO_WIDTH   = 8;
  localparam int         FIFO_DEPTH   = 8;

  // Link states of the serial front end.
  typedef enum logic [1:0] {LINK_IDLE, LINK_ACTIVE, LINK_PAUSED} sfp_link_type;

endpackage
